// [verilog/hsm_pkg.sv]
// constants shared by the readback device end and the bus controller end
// assumes a single 100 MHz system clock on both ends
package hsm_pkg;
  // bus address of the device (arbitrary value)
  localparam logic [6:0] DEV_ADDR = 7'h4A;
  // command byte fields
  localparam int CMD_V_CONT = 0;
  localparam int CMD_V_ONCE = 1;
  localparam int CMD_I_CONT = 2;
  localparam int CMD_I_ONCE = 3;
  localparam int CMD_STATUS_SEL = 6;
  localparam int CMD_EXT_BIT = 7;
  // extended register pointers
  localparam logic [1:0] EXT_ALERT_EN = 2'h1;
  localparam logic [1:0] EXT_IRQ_TH = 2'h2;
  localparam logic [1:0] EXT_CONTROL = 2'h3;
  // alert enable fields and defaults
  localparam int AEN_SINGLE = 0;
  localparam int AEN_FOUR = 1;
  localparam int AEN_HS = 2;
  localparam int AEN_OFF = 3;
  localparam int AEN_CLEAR = 4;
  localparam logic [3:0] ALERT_EN_RST = 4'h4;
  localparam logic [7:0] IRQ_TH_RST = 8'hFF;
  localparam logic [6:0] CMD_RST = 7'h00;
  localparam int CTL_SOFT_OFF = 0;
  // status byte fields
  localparam int ST_CONV_OC = 0;
  localparam int ST_ADC_ALERT = 1;
  localparam int ST_ANALOG = 2;
  localparam int ST_HS_FAULT = 3;
  localparam int ST_OFF = 4;
  localparam int ST_OFF_ALERT = 5;
  // result codes: unsigned, full scale 4096 counts
  localparam int CODE_W = 12;
  localparam int FULL_SCALE = 4096;
  // controller serial clock timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // controller register offsets and command fields
  localparam logic [7:0] HREG_CMD = 8'h00;
  localparam logic [7:0] HREG_STAT = 8'h04;
  localparam logic [7:0] HREG_RDATA = 8'h08;
  localparam logic [7:0] HREG_LINE = 8'h0C;
  localparam int HCMD_READ = 0;
  localparam int HCMD_NB_LO = 1;
  localparam int HCMD_ACK_LAST = 3;
  localparam int HCMD_D0_LO = 8;
  localparam int HCMD_D1_LO = 16;
  localparam int HSTAT_BUSY = 0;
  localparam int HSTAT_NACK = 1;
  // state encodings
  typedef enum logic [2:0] {
    D_IDLE = 3'h0, D_ADDR = 3'h1, D_AACK = 3'h2, D_WRX = 3'h3,
    D_WACK = 3'h4, D_TX = 3'h5, D_RACK = 3'h6
  } hsm_dst_e;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0, H_START = 2'h1, H_BIT = 2'h2, H_STOP = 2'h3
  } hsm_hst_e;
endpackage : hsm_pkg

// [verilog/hsm_i2c_if.sv]
// serial link between controller and device: clock, data and alert lines
// open-drain wires resolved here; each end drives with enable low
`timescale 1ns/1ps
interface hsm_i2c_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic dev_alert_o;
  logic dev_alert_oe_n;
  logic scl;
  logic sda;
  logic irq_out_n;
  // wired-and with external pull-ups
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
  assign irq_out_n = dev_alert_oe_n | dev_alert_o;
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n,
    output dev_alert_o, output dev_alert_oe_n);
  modport host (input scl, input sda, input irq_out_n, output host_scl_o,
    output host_scl_oe_n, output host_sda_o, output host_sda_oe_n);
endinterface : hsm_i2c_if

// [verilog/hsm_dev.sv]
// device end: serial slave, readback formats, status flags, alert pin
// assumes the link lines arrive asynchronously and the codes on i_clk
// Behaviour
// RULE_01: control bit 0 forces hot swap off
// RULE_02: combined read: V high, I high, nibbles
// RULE_03: voltage read: V high, then V low nibble
// RULE_04: current read: I high, then I low nibble
// RULE_05: read: address ack, master nacks last byte
// RULE_06: master stops after two bytes single-channel
// RULE_07: status read returns one byte
// RULE_08: status bit0: last three conversions over
// RULE_09: status bit1 latches on conversion trip
// RULE_10: status bit2 analog trip, per variant
// RULE_11: status bit3 latches on hot swap failure
// RULE_12: status bit4 shows off state
// RULE_13: status bit5 latches on shutdown
// RULE_14: clear bit clears latched bits 1,3,5
// RULE_15: alert pin open-drain, low when active
// RULE_16: alert on any enabled latched flag
// RULE_17: software enables latch and sets threshold
// RULE_18: alert disabled after power-up until enabled
// RULE_19: codes unsigned twelve bits, 4096 full scale
// RULE_20: extended write: pointer byte then data
// RULE_21: status select returns status byte
// RULE_22: clear self-clears, flags may reset again
// RULE_23: threshold vs upper eight current bits
// RULE_24: alert registered OR of flag and enable
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module hsm_dev (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // link
  hsm_i2c_if.dev bus,
  // measurement and power path
  input wire logic [hsm_pkg::CODE_W-1:0] i_volt_code,
  input wire logic [hsm_pkg::CODE_W-1:0] i_curr_code,
  input wire logic i_conv_done,
  input wire logic i_enable,
  input wire logic i_analog_trip,
  input wire logic i_hs_fail,
  input wire logic i_latch_variant,
  // results
  output logic o_hotswap_off,
  output logic [6:0] o_cmd
);
  import hsm_pkg::*;

  // byte returned at read index idx
  function automatic logic [7:0] fmt_byte(input logic [6:0] cmd, input logic [1:0] idx,
      input logic [11:0] v, input logic [11:0] c, input logic [7:0] st);
    logic vm;
    logic im;
    vm = cmd[CMD_V_CONT] | cmd[CMD_V_ONCE];
    im = cmd[CMD_I_CONT] | cmd[CMD_I_ONCE];
    fmt_byte = 8'h00;
    if (cmd[CMD_STATUS_SEL]) begin
      fmt_byte = (idx == 2'h0) ? st : 8'h00; // RULE_21
    end else if (vm && !im) begin
      fmt_byte = (idx == 2'h0) ? v[11:4] : {v[3:0], 4'h0}; // RULE_03
    end else if (im && !vm) begin
      fmt_byte = (idx == 2'h0) ? c[11:4] : {c[3:0], 4'h0}; // RULE_04
    end else begin
      case (idx) // RULE_02
        2'h0: fmt_byte = v[11:4];
        2'h1: fmt_byte = c[11:4];
        default: fmt_byte = {v[3:0], c[3:0]};
      endcase
    end
  endfunction : fmt_byte

  // index of the last byte of a read
  function automatic logic [1:0] last_idx(input logic [6:0] cmd);
    logic vm;
    logic im;
    vm = cmd[CMD_V_CONT] | cmd[CMD_V_ONCE];
    im = cmd[CMD_I_CONT] | cmd[CMD_I_ONCE];
    if (cmd[CMD_STATUS_SEL]) last_idx = 2'h0; // RULE_07
    else if (vm != im) last_idx = 2'h1; // RULE_06
    else last_idx = 2'h2;
  endfunction : last_idx

  ////////////////////////////////////////////////////////////////////////
  // line synchronisers: three stages, change taken when stages 2 and 3 agree
  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic scl_f_q;
  logic sda_f_q;
  logic scl_f_d;
  logic sda_f_d;

  always_comb begin
    scl_f_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
    sda_f_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], bus.scl};
      sda_s_q <= {sda_s_q[1:0], bus.sda};
      scl_f_q <= scl_f_d;
      sda_f_q <= sda_f_d;
    end
  end

  // edges and bus conditions, from filtered levels only
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_rise = scl_f_d & ~scl_f_q;
  assign scl_fall = ~scl_f_d & scl_f_q;
  assign start_c = scl_f_q & scl_f_d & sda_f_q & ~sda_f_d;
  assign stop_c = scl_f_q & scl_f_d & ~sda_f_q & sda_f_d;

  ////////////////////////////////////////////////////////////////////////
  // serial slave and register writes
  hsm_dst_e st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] shf_q, shf_d;
  logic rw_q, rw_d;
  logic ack_on_q, ack_on_d;
  logic wbi_q, wbi_d;
  logic ext_q, ext_d;
  logic [1:0] ptr_q, ptr_d;
  logic [1:0] rbi_q, rbi_d;
  logic [7:0] txb_q, txb_d;
  logic drv_q, drv_d;
  logic [11:0] vsnap_q, vsnap_d;
  logic [11:0] isnap_q, isnap_d;
  logic [6:0] cmd_q, cmd_d;
  logic [3:0] aen_q, aen_d;
  logic [7:0] th_q, th_d;
  logic soft_shutdown_bit_q, soft_shutdown_bit_d;
  logic clr_q, clr_d;
  logic armed_q, armed_d;
  logic [7:0] status;
  logic [7:0] rx_byte;

  assign rx_byte = {shf_q[6:0], sda_f_d};

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    shf_d = shf_q;
    rw_d = rw_q;
    ack_on_d = ack_on_q;
    wbi_d = wbi_q;
    ext_d = ext_q;
    ptr_d = ptr_q;
    rbi_d = rbi_q;
    txb_d = txb_q;
    drv_d = drv_q;
    vsnap_d = vsnap_q;
    isnap_d = isnap_q;
    cmd_d = cmd_q;
    aen_d = aen_q;
    th_d = th_q;
    soft_shutdown_bit_d = soft_shutdown_bit_q;
    clr_d = 1'b0; // RULE_22
    armed_d = armed_q;
    if (start_c) begin
      st_d = D_ADDR;
      cnt_d = 3'h0;
      drv_d = 1'b0;
    end else if (stop_c) begin
      st_d = D_IDLE;
      drv_d = 1'b0;
    end else if (scl_rise) begin
      case (st_q)
        D_ADDR, D_WRX: begin
          shf_d = rx_byte;
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == 3'h7) begin
            if (st_q == D_WRX) begin
              st_d = D_WACK;
              wbi_d = 1'b1;
              if (!wbi_q && !rx_byte[CMD_EXT_BIT]) begin
                cmd_d = rx_byte[6:0];
              end else if (!wbi_q) begin
                ext_d = 1'b1; // RULE_20
                ptr_d = rx_byte[1:0];
              end else if (ext_q) begin
                ext_d = 1'b0;
                case (ptr_q)
                  EXT_ALERT_EN: begin
                    aen_d = rx_byte[3:0];
                    clr_d = rx_byte[AEN_CLEAR]; // RULE_14
                    armed_d = 1'b1; // RULE_18
                  end
                  EXT_IRQ_TH: th_d = rx_byte;
                  EXT_CONTROL: soft_shutdown_bit_d = rx_byte[CTL_SOFT_OFF]; // RULE_01
                  default: ;
                endcase
              end
            end else if (rx_byte[7:1] == DEV_ADDR) begin
              st_d = D_AACK; // RULE_05
              rw_d = rx_byte[0];
              wbi_d = 1'b0;
              ext_d = 1'b0;
              rbi_d = 2'h0;
              vsnap_d = i_volt_code; // RULE_19
              isnap_d = i_curr_code;
            end else begin
              st_d = D_IDLE;
            end
          end
        end
        D_TX: begin
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == 3'h7) st_d = D_RACK;
        end
        D_RACK: begin
          // master nack, or last byte of the format, ends the read
          if (sda_f_d || rbi_q == last_idx(cmd_q)) begin // RULE_05
            st_d = D_IDLE;
          end else begin
            st_d = D_TX;
            cnt_d = 3'h0;
            rbi_d = rbi_q + 2'h1;
            txb_d = fmt_byte(cmd_q, rbi_q + 2'h1, vsnap_q, isnap_q, status);
          end
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st_q)
        D_AACK, D_WACK: begin
          if (!ack_on_q) begin
            ack_on_d = 1'b1;
            drv_d = 1'b1;
          end else begin
            ack_on_d = 1'b0;
            cnt_d = 3'h0;
            if (st_q == D_AACK && rw_q) begin
              st_d = D_TX;
              txb_d = fmt_byte(cmd_q, 2'h0, vsnap_q, isnap_q, status);
              drv_d = ~txb_d[7];
            end else begin
              st_d = D_WRX;
              drv_d = 1'b0;
            end
          end
        end
        D_TX: drv_d = ~txb_q[3'h7 - cnt_q];
        default: drv_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= D_IDLE;
      cnt_q <= 3'h0;
      shf_q <= 8'h00;
      rw_q <= 1'b0;
      ack_on_q <= 1'b0;
      wbi_q <= 1'b0;
      ext_q <= 1'b0;
      ptr_q <= 2'h0;
      rbi_q <= 2'h0;
      txb_q <= 8'h00;
      drv_q <= 1'b0;
      vsnap_q <= 12'h000;
      isnap_q <= 12'h000;
      cmd_q <= CMD_RST;
      aen_q <= ALERT_EN_RST;
      th_q <= IRQ_TH_RST;
      soft_shutdown_bit_q <= 1'b0;
      clr_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      shf_q <= shf_d;
      rw_q <= rw_d;
      ack_on_q <= ack_on_d;
      wbi_q <= wbi_d;
      ext_q <= ext_d;
      ptr_q <= ptr_d;
      rbi_q <= rbi_d;
      txb_q <= txb_d;
      drv_q <= drv_d;
      vsnap_q <= vsnap_d;
      isnap_q <= isnap_d;
      cmd_q <= cmd_d;
      aen_q <= aen_d;
      th_q <= th_d;
      soft_shutdown_bit_q <= soft_shutdown_bit_d;
      clr_q <= clr_d;
      armed_q <= armed_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags and alert; a set in the clear cycle wins
  logic [3:0] hist_q, hist_d;
  logic adc_q, adc_d;
  logic hsf_q, hsf_d;
  logic offa_q, offa_d;
  logic offp_q, offp_d;
  logic irq_q, irq_d;
  logic over;
  logic off_now;

  assign over = i_curr_code[11:4] > th_q; // RULE_23
  assign off_now = ~i_enable | soft_shutdown_bit_q; // RULE_01

  always_comb begin
    hist_d = i_conv_done ? {hist_q[2:0], over} : hist_q;
    adc_d = (i_conv_done & over & (aen_q[AEN_SINGLE] | (aen_q[AEN_FOUR] & (&hist_q[2:0]))))
      | (adc_q & ~clr_q); // RULE_09
    hsf_d = i_hs_fail | (hsf_q & ~clr_q); // RULE_11
    offa_d = (off_now & ~offp_q) | (offa_q & ~clr_q); // RULE_13
    offp_d = off_now;
    irq_d = armed_q & ((adc_q & (aen_q[AEN_SINGLE] | aen_q[AEN_FOUR]))
      | (hsf_q & aen_q[AEN_HS]) | (offa_q & aen_q[AEN_OFF])); // RULE_16 RULE_24
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hist_q <= 4'h0;
      adc_q <= 1'b0;
      hsf_q <= 1'b0;
      offa_q <= 1'b0;
      offp_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      hist_q <= hist_d;
      adc_q <= adc_d;
      hsf_q <= hsf_d;
      offa_q <= offa_d;
      offp_q <= offp_d;
      irq_q <= irq_d;
    end
  end

  // status byte; bits 7:6 read zero
  always_comb begin
    status = 8'h00;
    status[ST_CONV_OC] = &hist_q[2:0]; // RULE_08
    status[ST_ADC_ALERT] = adc_q;
    status[ST_ANALOG] = i_latch_variant ? (hsf_q & aen_q[AEN_HS]) : i_analog_trip; // RULE_10
    status[ST_HS_FAULT] = hsf_q;
    status[ST_OFF] = off_now; // RULE_12
    status[ST_OFF_ALERT] = offa_q;
  end

  // open-drain pins only ever pull low
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe_n = ~drv_q;
  assign bus.dev_alert_o = 1'b0; // RULE_15
  assign bus.dev_alert_oe_n = ~irq_q;
  assign o_hotswap_off = offp_q;
  assign o_cmd = cmd_q;
endmodule : hsm_dev

// [verilog/hsm_host.sv]
// controller end: AHB-Lite register slave driving a serial bus master
// assumes one AHB-Lite master; device lines arrive asynchronously
`timescale 1ns/1ps
module hsm_host (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // link
  hsm_i2c_if.host bus
);
  import hsm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // data and alert line synchronisers
  logic [2:0] sda_s_q;
  logic [2:0] irq_s_q;
  logic sda_f_q;
  logic irq_f_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sda_s_q <= 3'h7;
      irq_s_q <= 3'h7;
      sda_f_q <= 1'b1;
      irq_f_q <= 1'b1;
    end else begin
      sda_s_q <= {sda_s_q[1:0], bus.sda};
      irq_s_q <= {irq_s_q[1:0], bus.irq_out_n};
      sda_f_q <= (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
      irq_f_q <= (irq_s_q[1] == irq_s_q[2]) ? irq_s_q[2] : irq_f_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus slave and serial sequencer; zero wait states, always OKAY
  hsm_hst_e st_q, st_d;
  logic [5:0] div_q, div_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] bitc_q, bitc_d;
  logic [1:0] byc_q, byc_d;
  logic [1:0] nby_q, nby_d;
  logic rw_q, rw_d;
  logic ackl_q, ackl_d;
  logic [7:0] shf_q, shf_d;
  logic [7:0] d0_q, d0_d;
  logic [7:0] d1_q, d1_d;
  logic [23:0] rdat_q, rdat_d;
  logic nack_q, nack_d;
  logic scl_q, scl_d;
  logic sda_q, sda_d;
  logic wpend_q, wpend_d;
  logic [31:0] hrd_q, hrd_d;
  logic tick;
  logic tx;
  logic go;

  assign tick = div_q == 6'(QTR_CYC - 1);
  assign tx = (byc_q == 2'h0) | ~rw_q;
  assign go = wpend_q & (st_q == H_IDLE);

  always_comb begin
    st_d = st_q;
    div_d = tick ? 6'h00 : div_q + 6'h01;
    ph_d = ph_q;
    bitc_d = bitc_q;
    byc_d = byc_q;
    nby_d = nby_q;
    rw_d = rw_q;
    ackl_d = ackl_q;
    shf_d = shf_q;
    d0_d = d0_q;
    d1_d = d1_q;
    rdat_d = rdat_q;
    nack_d = nack_q;
    scl_d = scl_q;
    sda_d = sda_q;
    wpend_d = 1'b0;
    hrd_d = hrd_q;
    // address phase: capture writes, prepare read data
    if (i_hsel && i_htrans[1] && i_hready) begin
      wpend_d = i_hwrite && (i_haddr[7:0] == HREG_CMD);
      case (i_haddr[7:0])
        HREG_STAT: hrd_d = {30'h0, nack_q, st_q != H_IDLE};
        HREG_RDATA: hrd_d = {8'h00, rdat_q};
        HREG_LINE: hrd_d = {30'h0, sda_f_q, irq_f_q};
        default: hrd_d = 32'h0000_0000;
      endcase
    end
    if (go) begin
      st_d = H_START;
      ph_d = 2'h0;
      div_d = 6'h00;
      rw_d = i_hwdata[HCMD_READ];
      nby_d = i_hwdata[HCMD_NB_LO +: 2];
      ackl_d = i_hwdata[HCMD_ACK_LAST];
      d0_d = i_hwdata[HCMD_D0_LO +: 8];
      d1_d = i_hwdata[HCMD_D1_LO +: 8];
      nack_d = 1'b0;
      rdat_d = 24'h000000;
    end else if (tick && st_q != H_IDLE) begin
      ph_d = ph_q + 2'h1;
      case (st_q)
        H_START: begin
          if (ph_q == 2'h1) sda_d = 1'b0;
          if (ph_q == 2'h2) begin
            scl_d = 1'b0;
            st_d = H_BIT;
            ph_d = 2'h0;
            bitc_d = 4'h0;
            byc_d = 2'h0;
            shf_d = {DEV_ADDR, rw_q}; // RULE_05
          end
        end
        H_BIT: begin
          case (ph_q)
            2'h0: begin
              if (bitc_q == 4'h8) sda_d = tx | (byc_q == nby_q && !ackl_q); // RULE_05 RULE_07
              else sda_d = ~tx | shf_q[7];
            end
            2'h1: scl_d = 1'b1;
            2'h2: begin
              if (bitc_q != 4'h8) shf_d = {shf_q[6:0], sda_f_q};
              else if (tx && sda_f_q) nack_d = 1'b1;
            end
            default: begin
              scl_d = 1'b0;
              bitc_d = bitc_q + 4'h1;
              if (bitc_q == 4'h8) begin
                if (!tx) rdat_d = {rdat_q[15:0], shf_q};
                bitc_d = 4'h0;
                // last byte or refused byte ends the transfer
                if (nack_q || byc_q == nby_q) begin // RULE_06
                  st_d = H_STOP;
                end else begin
                  byc_d = byc_q + 2'h1;
                  shf_d = rw_q ? 8'hFF : ((byc_q == 2'h0) ? d0_q : d1_q); // RULE_20
                end
              end
            end
          endcase
        end
        H_STOP: begin
          case (ph_q)
            2'h0: sda_d = 1'b0;
            2'h1: scl_d = 1'b1;
            2'h2: sda_d = 1'b1;
            default: st_d = H_IDLE;
          endcase
        end
        default: st_d = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= H_IDLE;
      div_q <= 6'h00;
      ph_q <= 2'h0;
      bitc_q <= 4'h0;
      byc_q <= 2'h0;
      nby_q <= 2'h0;
      rw_q <= 1'b0;
      ackl_q <= 1'b0;
      shf_q <= 8'h00;
      d0_q <= 8'h00;
      d1_q <= 8'h00;
      rdat_q <= 24'h000000;
      nack_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      wpend_q <= 1'b0;
      hrd_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      ph_q <= ph_d;
      bitc_q <= bitc_d;
      byc_q <= byc_d;
      nby_q <= nby_d;
      rw_q <= rw_d;
      ackl_q <= ackl_d;
      shf_q <= shf_d;
      d0_q <= d0_d;
      d1_q <= d1_d;
      rdat_q <= rdat_d;
      nack_q <= nack_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      wpend_q <= wpend_d;
      hrd_q <= hrd_d;
    end
  end

  // open-drain: a one releases the line
  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe_n = scl_q;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe_n = sda_q;
  assign o_hrdata = hrd_q;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
endmodule : hsm_host

// [tb/hsm_checker.sv]
// link checks between controller end and device end
// assumes the link wires and both ends run on i_clk
`timescale 1ns/1ps
module hsm_checker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // link lines
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic dev_alert_o,
  input wire logic host_sda_oe_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic irq_out_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  //////////////////////////////
  // open-drain: only ever pull low
  property p_alert_od; !dev_alert_o; endproperty
  a_alert_od: assert property (p_alert_od) else $error("alert pin driven high");
  property p_sda_od; !dev_sda_o; endproperty
  a_sda_od: assert property (p_sda_od) else $error("data driven high");
  // alert stays off for eight cycles after power-up
  property p_rst_quiet; (!i_rst && $past(i_rst)) |-> irq_out_n [*8]; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("alert after reset");
  // device moves data only while the clock is low
  property p_dev_low; $changed(dev_sda_oe_n) |-> !scl; endproperty
  a_dev_low: assert property (p_dev_low) else $error("device data moved, clock high");
  // start and stop belong to the controller alone
  property p_frame; (scl && $past(scl) && $changed(sda)) |-> dev_sda_oe_n; endproperty
  a_frame: assert property (p_frame) else $error("device framed the bus");
  // while the clock is high only one end may hold data low
  property p_contend; (!dev_sda_oe_n && scl) |-> host_sda_oe_n; endproperty
  a_contend: assert property (p_contend) else $error("both ends drive data");
  property p_scl_hi; $rose(scl) |-> scl [*8]; endproperty
  a_scl_hi: assert property (p_scl_hi) else $error("clock high too short");
  property p_scl_lo; $fell(scl) |-> !scl [*8]; endproperty
  a_scl_lo: assert property (p_scl_lo) else $error("clock low too short");
  // latched flags keep the alert low, clearing needs a whole write
  property p_irq_hold; $fell(irq_out_n) |-> !irq_out_n [*8]; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("alert not held");
endmodule : hsm_checker

// [tb/tb_hot_swap_monitor_readback.sv]
// bench: AHB-Lite orders to the controller, which talks to the device
// assumes both ends and the link interface from the design folder
`timescale 1ns/1ps
module tb_hot_swap_monitor_readback;
  import hsm_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, conv = 1'b0, fail = 1'b0, trip = 1'b0, en = 1'b1, lat = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [11:0] volt = 12'hA5C, curr = 12'h3B7;
  logic hready, hresp, off;
  logic [6:0] cmd;
  int fails = 0, check_count = 0, cyc = 0;
  logic [7:0] mode [3] = '{8'h05, 8'h01, 8'h04};
  logic [23:0] expv [3] = '{24'hA53BC7, 24'h00A5C0, 24'h003B70};
  always #5 i_clk = ~i_clk;
  hsm_i2c_if i_hsm_i2c_if ();
  hsm_host i_hsm_host (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .bus(i_hsm_i2c_if));
  hsm_dev i_hsm_dev (.i_clk(i_clk), .i_rst(i_rst), .bus(i_hsm_i2c_if), .i_volt_code(volt),
    .i_curr_code(curr), .i_conv_done(conv), .i_enable(en), .i_analog_trip(trip),
    .i_hs_fail(fail), .i_latch_variant(lat), .o_hotswap_off(off), .o_cmd(cmd));
  hsm_checker i_hsm_checker (.i_clk(i_clk), .i_rst(i_rst),
    .dev_sda_o(i_hsm_i2c_if.dev_sda_o), .dev_sda_oe_n(i_hsm_i2c_if.dev_sda_oe_n),
    .dev_alert_o(i_hsm_i2c_if.dev_alert_o), .host_sda_oe_n(i_hsm_i2c_if.host_sda_oe_n),
    .scl(i_hsm_i2c_if.scl), .sda(i_hsm_i2c_if.sda), .irq_out_n(i_hsm_i2c_if.irq_out_n));
  //////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one single AHB-Lite transfer, read data left in r
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge i_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb
  // post a serial order, poll busy, fetch shifted bytes
  task automatic xfer(input logic [31:0] c);
    ahb(1'b1, HREG_CMD, c);
    repeat (2) @(posedge i_clk);
    do ahb(1'b0, HREG_STAT, 32'h0); while (r[HSTAT_BUSY] !== 1'b0);
    chk({31'h0, r[HSTAT_NACK]}, 32'h0);
    ahb(1'b0, HREG_RDATA, 32'h0);
  endtask : xfer
  function automatic logic [31:0] wcmd(input logic [7:0] b0, input logic [7:0] b1);
    return {8'h0, b1, b0, 5'h0, (b0[7] ? 2'h2 : 2'h1), 1'b0};
  endfunction : wcmd
  // status read: one byte, acknowledged by the controller
  task automatic st(input logic [31:0] exp);
    xfer(32'h0000000B);
    chk({24'h0, r[7:0]}, exp);
  endtask : st
  //////////////////////////////
  // hang guard, only about a tenth above the expected run of some 108000 cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 120000) begin
      fails = fails + 1;
      results();
    end
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    chk({31'h0, i_hsm_i2c_if.irq_out_n}, 32'h1);
    ahb(1'b0, 8'h10, 32'h0);
    chk(r | {31'h0, hresp}, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      xfer(wcmd(mode[i], 8'h00));
      xfer(i == 0 ? 32'h7 : 32'h5);
      chk({8'h0, r[23:0] & (i == 0 ? 24'hFFFFFF : 24'h00FFFF)}, {8'h0, expv[i]});
    end
    $display("test formats done");
    xfer(wcmd(8'h40, 8'h00));
    chk({25'h0, cmd}, 32'h40);
    xfer(wcmd(8'h83, 8'h01));
    xfer(wcmd(8'h81, 8'h08));
    chk({30'h0, off, i_hsm_i2c_if.irq_out_n}, 32'h2);
    ahb(1'b0, HREG_LINE, 32'h0);
    chk(r, 32'h2);
    st(32'h30);
    xfer(wcmd(8'h83, 8'h00));
    en <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk({31'h0, off}, 32'h1);
    en <= 1'b1;
    xfer(wcmd(8'h81, 8'h18));
    chk({30'h0, off, i_hsm_i2c_if.irq_out_n}, 32'h1);
    $display("test shutdown done");
    xfer(wcmd(8'h82, 8'h10));
    xfer(wcmd(8'h81, 8'h05));
    curr <= 12'h200;
    trip <= 1'b1;
    repeat (3) begin
      conv <= 1'b1;
      @(posedge i_clk);
      conv <= 1'b0;
      @(posedge i_clk);
    end
    fail <= 1'b1;
    @(posedge i_clk);
    fail <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk({31'h0, i_hsm_i2c_if.irq_out_n}, 32'h0);
    lat <= 1'b1;
    st(32'h0F);
    xfer(wcmd(8'h81, 8'h10));
    lat <= 1'b0;
    st(32'h05);
    chk({31'h0, i_hsm_i2c_if.irq_out_n}, 32'h1);
    $display("test overcurrent done");
    results();
  end
endmodule : tb_hot_swap_monitor_readback
